//--- rtl/usf_top.v
// Serial transceiver status flags with APB register access
//
// Local design decisions: register access over APB and the register addresses.
`include "usf_map.vh"
`default_nettype none
// Functional notes
// RULE1: Done flag clears after status read, tx action
// RULE2: Done flag low while sending, high after
// RULE3: Full flag sets when character reaches register
// RULE4: Full flag clears by status, data read
// RULE5: Quiet flag sets after character of high
// RULE6: Character time is 10 or 11 bits
// RULE7: Select 0 counts idle from after start
// RULE8: Select 1 counts idle after stop bits
// RULE9: Quiet flag clears by status, data read
// RULE10: Quiet flag rearms only after new character
// RULE11: Quiet flag sets once per idle period
// RULE12: Overrun sets when new char meets unread
// RULE13: Overrun drops new character and its errors
// RULE14: Overrun clears by status, data read
// RULE15: Seven start samples, three per bit
// RULE16: Noise flag sets with full on disagreement
// RULE17: Noise flag clears by status, data read; any status read arms the clear, even one that sees the flag low
// RULE18: Done flag set at reset and idle
// RULE19: Status register is read-only
// RULE20: Receive flags are zero after reset
module usf_top (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd_pin,
  output reg txd_pin
);
  // ==========================================
  // Registers and state
  reg [7:0] ctrl_reg;
  reg [15:0] baud_reg;
  reg [15:0] baud_cnt_reg;
  reg tick_reg;
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg [8:0] tdr_reg;
  reg [8:0] rdr_reg;
  reg txe_reg;
  reg txdone_reg;
  reg rxfull_reg;
  reg idle_reg;
  reg or_reg;
  reg noisy_reg;
  reg idle_allow_reg;
  reg arm_txe_reg;
  reg arm_txdone_reg;
  reg arm_rxfull_reg;
  reg arm_idle_reg;
  reg arm_or_reg;
  reg arm_noisy_reg;
  reg pre_pend_reg;
  reg brk_pend_reg;
  reg [10:0] tx_shift_reg;
  reg [3:0] tx_left_reg;
  reg [3:0] tx_sub_reg;
  wire rx_valid;
  wire [8:0] rx_data;
  wire rx_noise;
  wire idle_hit;

  wire tx_on = ctrl_reg[`USF_CT_TXON];
  wire nine_bits = ctrl_reg[`USF_CT_LONG];
  wire [3:0] frame_len = nine_bits ? `USF_FRAME_LONG : `USF_FRAME_SHORT;

  // ==========================================
  // APB decode: one wait state, effects at the completing edge
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = addr == ofs;
    end
  endfunction

  wire acc_done = psel && penable && pready;
  wire wr_done = acc_done && pwrite;
  wire rd_done = acc_done && !pwrite;
  wire mapped = hit(paddr, `USF_OFS_DATA) || hit(paddr, `USF_OFS_STATUS) ||
                hit(paddr, `USF_OFS_CTRL) || hit(paddr, `USF_OFS_BAUD);
  wire st_read = rd_done && hit(paddr, `USF_OFS_STATUS);
  wire data_read = rd_done && hit(paddr, `USF_OFS_DATA);
  wire data_write = wr_done && hit(paddr, `USF_OFS_DATA);
  wire ctrl_write = wr_done && hit(paddr, `USF_OFS_CTRL);
  wire txon_rise = ctrl_write && !tx_on && pwdata[`USF_CT_TXON];
  wire brk_write = ctrl_write && pwdata[`USF_CT_BREAK];
  wire tx_action = data_write || txon_rise || brk_write;
  wire [7:0] status = {txe_reg, txdone_reg, rxfull_reg, idle_reg, or_reg, noisy_reg, 2'b00};

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, `USF_OFS_DATA))
      rd_mux = {23'h0, rdr_reg};
    else if (hit(paddr, `USF_OFS_STATUS))
      rd_mux = {24'h000000, status};
    else if (hit(paddr, `USF_OFS_CTRL))
      rd_mux = {24'h000000, ctrl_reg};
    else if (hit(paddr, `USF_OFS_BAUD))
      rd_mux = {16'h0000, baud_reg};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ==========================================
  // Software registers; status offset takes no writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `USF_CTRL_RST;
      baud_reg <= `USF_BAUD_RST;
      tdr_reg <= 9'h000;
    end else if (ce) begin
      if (ctrl_write)
        ctrl_reg <= pwdata[7:0];
      if (wr_done && hit(paddr, `USF_OFS_BAUD))
        baud_reg <= pwdata[15:0];
      if (data_write)
        tdr_reg <= pwdata[8:0];
    end
  end

  // ==========================================
  // Baud tick and receive pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else if (ce) begin
      rx_meta_reg <= rxd_pin;
      rx_sync_reg <= rx_meta_reg;
      tick_reg <= 1'b0;
      if (baud_cnt_reg >= baud_reg) begin
        baud_cnt_reg <= 16'h0000;
        tick_reg <= 1'b1;
      end else begin
        baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      end
    end
  end

  usf_rx_core u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick_reg),
    .rxd(rx_sync_reg),
    .nine_bits(nine_bits),
    .quiet_sel(ctrl_reg[`USF_CT_QUIET]),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_noise(rx_noise),
    .idle_hit(idle_hit)
  );

  // ==========================================
  // Transmitter: data, preamble and break frames
  wire tx_busy = tx_left_reg != 4'h0;
  wire tx_start = tx_on && !tx_busy && tick_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_reg <= 11'h7ff;
      tx_left_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
      txe_reg <= 1'b1;
      pre_pend_reg <= 1'b0;
      brk_pend_reg <= 1'b0;
      txd_pin <= 1'b1;
    end else if (ce) begin
      txd_pin <= (tx_on && tx_busy) ? tx_shift_reg[0] : 1'b1;
      if (txon_rise)
        pre_pend_reg <= 1'b1;
      if (brk_write)
        brk_pend_reg <= 1'b1;
      if (data_write && arm_txe_reg)
        txe_reg <= 1'b0;
      if (tx_busy && tick_reg) begin
        tx_sub_reg <= tx_sub_reg + 4'h1;
        if (tx_sub_reg == `USF_TICK_LAST) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
        end
      end else if (tx_start) begin
        tx_sub_reg <= 4'h0;
        if (pre_pend_reg) begin
          tx_shift_reg <= 11'h7ff;
          tx_left_reg <= frame_len;
          pre_pend_reg <= txon_rise;
        end else if (brk_pend_reg || ctrl_reg[`USF_CT_BREAK]) begin
          tx_shift_reg <= 11'h000;
          tx_left_reg <= frame_len;
          brk_pend_reg <= brk_write;
        end else if (!txe_reg) begin
          tx_shift_reg <= nine_bits ? {1'b1, tdr_reg, 1'b0} : {2'b11, tdr_reg[7:0], 1'b0};
          tx_left_reg <= frame_len;
          txe_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Status flags and two-step clearing sequences
  wire tx_quiet = txe_reg && !tx_busy && !pre_pend_reg && !brk_pend_reg &&
                  !ctrl_reg[`USF_CT_BREAK];
  wire rxfull_clr = data_read && arm_rxfull_reg;
  wire rx_load = rx_valid && (!rxfull_reg || rxfull_clr);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txdone_reg <= 1'b1; // RULE18
      rxfull_reg <= 1'b0; // RULE20
      idle_reg <= 1'b0;
      or_reg <= 1'b0;
      noisy_reg <= 1'b0;
      idle_allow_reg <= 1'b0;
      rdr_reg <= 9'h000;
      arm_txe_reg <= 1'b0;
      arm_txdone_reg <= 1'b0;
      arm_rxfull_reg <= 1'b0;
      arm_idle_reg <= 1'b0;
      arm_or_reg <= 1'b0;
      arm_noisy_reg <= 1'b0;
    end else if (ce) begin
      if (st_read) begin
        arm_txe_reg <= txe_reg;
        arm_txdone_reg <= txdone_reg; // RULE1
        arm_rxfull_reg <= rxfull_reg; // RULE4
        arm_idle_reg <= idle_reg; // RULE9
        arm_or_reg <= or_reg; // RULE14
        arm_noisy_reg <= 1'b1; // RULE17
      end else begin
        if (data_read) begin
          arm_rxfull_reg <= 1'b0;
          arm_idle_reg <= 1'b0;
          arm_or_reg <= 1'b0;
          arm_noisy_reg <= 1'b0;
        end
        if (tx_action) begin
          arm_txdone_reg <= 1'b0;
          arm_txe_reg <= 1'b0;
        end
      end
      if (tx_quiet)
        txdone_reg <= 1'b1; // RULE18 RULE2
      else if (tx_busy || (tx_action && arm_txdone_reg))
        txdone_reg <= 1'b0; // RULE1 RULE2
      if (rx_load) begin
        rdr_reg <= rx_data;
        rxfull_reg <= 1'b1; // RULE3
        noisy_reg <= rx_noise; // RULE16
        idle_allow_reg <= 1'b1; // RULE10
      end else begin
        if (rxfull_clr)
          rxfull_reg <= 1'b0; // RULE4
        if (data_read && arm_noisy_reg)
          noisy_reg <= 1'b0; // RULE17
      end
      if (rx_valid && rxfull_reg && !rxfull_clr)
        or_reg <= 1'b1; // RULE12 RULE13
      else if (data_read && arm_or_reg)
        or_reg <= 1'b0; // RULE14
      if (idle_hit && idle_allow_reg && !rx_load) begin
        idle_reg <= 1'b1; // RULE5
        idle_allow_reg <= 1'b0; // RULE11
      end else if (data_read && arm_idle_reg) begin
        idle_reg <= 1'b0; // RULE9
      end
    end
  end
  // Status offset has no write path: RULE19
endmodule
`default_nettype wire

//--- include/usf_map.vh
// Register map, field positions, reset values and timing counts of the serial status block
`ifndef USF_MAP_VH
`define USF_MAP_VH
// ==========================================
// Register offsets (byte addresses)
`define USF_OFS_DATA 8'h00
`define USF_OFS_STATUS 8'h04
`define USF_OFS_CTRL 8'h08
`define USF_OFS_BAUD 8'h0c
// ==========================================
// Status register bit positions
`define USF_ST_TXEMPTY 7
`define USF_ST_TXDONE 6
`define USF_ST_RXFULL 5
`define USF_ST_QUIET 4
`define USF_ST_OVERRUN 3
`define USF_ST_NOISE 2
// ==========================================
// Control register bit positions
`define USF_CT_BREAK 0
`define USF_CT_TXON 1
`define USF_CT_LONG 3
`define USF_CT_QUIET 4
// ==========================================
// Reset values
`define USF_CTRL_RST 8'h00
`define USF_BAUD_RST 16'h0036
// ==========================================
// Oversampling: 16 ticks per bit time
`define USF_TICK_LAST 4'hf
`define USF_START_FIRST 4'h3
`define USF_SAMPLE_FIRST 4'h7
`define USF_SAMPLE_LAST 4'h9
`define USF_FRAME_SHORT 4'ha
`define USF_FRAME_LONG 4'hb
`endif

//--- rtl/usf_rx_core.v
// Oversampling receiver with noise detection and idle-time counting
`include "usf_map.vh"
`default_nettype none
module usf_rx_core (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire tick,
  input wire rxd,
  input wire nine_bits,
  input wire quiet_sel,
  output reg rx_valid,
  output reg [8:0] rx_data,
  output reg rx_noise,
  output reg idle_hit
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_START = 2'd1;
  localparam [1:0] ST_DATA = 2'd2;
  localparam [1:0] ST_STOP = 2'd3;

  reg [1:0] state_reg;
  reg [3:0] sub_reg;
  reg [3:0] bit_reg;
  reg [2:0] ones_reg;
  reg noise_reg;
  reg [8:0] shift_reg;
  reg [3:0] quiet_reg;
  wire [3:0] frame_len = nine_bits ? `USF_FRAME_LONG : `USF_FRAME_SHORT;
  wire [3:0] last_bit = nine_bits ? 4'h8 : 4'h7;
  wire [2:0] ones_next = ones_reg + {2'b00, rxd};
  wire in_window = (sub_reg >= `USF_SAMPLE_FIRST) && (sub_reg <= `USF_SAMPLE_LAST);
  wire bit_val = ones_next >= 3'd2;

  // ==========================================
  // Sample helpers
  function disagree;
    input [2:0] ones;
    input [2:0] n;
    begin
      disagree = (ones != 3'd0) && (ones != n);
    end
  endfunction

  function [3:0] bump;
    input [3:0] cnt;
    input [3:0] len;
    begin
      bump = (cnt == len) ? cnt : cnt + 4'h1;
    end
  endfunction

  // ==========================================
  // Frame state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      sub_reg <= 4'h0;
      bit_reg <= 4'h0;
      ones_reg <= 3'd0;
      noise_reg <= 1'b0;
      shift_reg <= 9'h000;
      quiet_reg <= 4'h0;
      rx_valid <= 1'b0;
      rx_data <= 9'h000;
      rx_noise <= 1'b0;
      idle_hit <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      idle_hit <= 1'b0;
      if (tick) begin
        sub_reg <= sub_reg + 4'h1;
        case (state_reg)
          ST_IDLE: begin
            if (!rxd) begin
              state_reg <= ST_START;
              sub_reg <= 4'h0;
              ones_reg <= 3'd0;
              noise_reg <= 1'b0;
              bit_reg <= 4'h0;
              if (quiet_sel)
                quiet_reg <= 4'h0; // RULE8
            end else if (sub_reg == `USF_TICK_LAST) begin
              quiet_reg <= bump(quiet_reg, frame_len);
              idle_hit <= (quiet_reg != frame_len) &&
                          (bump(quiet_reg, frame_len) == frame_len); // RULE5 RULE6
            end
          end
          ST_START: begin
            if (sub_reg >= `USF_START_FIRST && sub_reg <= `USF_SAMPLE_LAST)
              ones_reg <= ones_next; // RULE15
            if (sub_reg == `USF_SAMPLE_LAST) begin
              if (ones_next >= 3'd4) begin
                state_reg <= ST_IDLE;
              end else begin
                noise_reg <= disagree(ones_next, 3'd7); // RULE16
                quiet_reg <= 4'h0; // RULE7
              end
            end
            if (sub_reg == `USF_TICK_LAST) begin
              state_reg <= ST_DATA;
              ones_reg <= 3'd0;
            end
          end
          ST_DATA: begin
            if (in_window)
              ones_reg <= ones_next; // RULE15
            if (sub_reg == `USF_SAMPLE_LAST) begin
              shift_reg <= {bit_val, shift_reg[8:1]};
              noise_reg <= noise_reg | disagree(ones_next, 3'd3); // RULE16
              if (!quiet_sel)
                quiet_reg <= bit_val ? bump(quiet_reg, frame_len) : 4'h0; // RULE7
            end
            if (sub_reg == `USF_TICK_LAST) begin
              ones_reg <= 3'd0;
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == last_bit)
                state_reg <= ST_STOP;
            end
          end
          default: begin
            if (in_window)
              ones_reg <= ones_next;
            if (sub_reg == `USF_SAMPLE_LAST) begin
              state_reg <= ST_IDLE;
              rx_valid <= 1'b1;
              rx_data <= nine_bits ? shift_reg : {1'b0, shift_reg[8:1]};
              rx_noise <= noise_reg | disagree(ones_next, 3'd3); // RULE16
              if (!quiet_sel)
                quiet_reg <= bump(quiet_reg, frame_len); // RULE7
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/usf_top_chk.sv
// Port assertions for the serial status block
`include "usf_map.vh"
`default_nettype none
module usf_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic st_rd;
  logic bad_a;
  assign st_rd = psel && penable && pready && !pwrite && paddr == `USF_OFS_STATUS;
  assign bad_a = paddr > `USF_OFS_BAUD || paddr[1:0] != 2'b00;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // Bus timing and refusals
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access not answered after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (psel && penable && pready |-> pslverr == bad_a)
    else $error("error response does not match address");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // ====
  // Status contents
  a_status_reserved: assert property (st_rd |-> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0)
    else $error("status unused bits set");
  a_tc_with_tx_buffer_empty_flag: assert property (st_rd && prdata[6] |-> prdata[7])
    else $error("complete flag without empty buffer");
  a_tc_line_high: assert property (st_rd && prdata[6] |-> txd_pin)
    else $error("complete flag while line driven low");
  a_noise_with_full: assert property (st_rd && prdata[2] |-> prdata[5])
    else $error("noise flag without full flag");
endmodule
bind usf_top usf_top_chk u_usf_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd_pin(txd_pin));
`default_nettype wire

//--- tb/usf_far_end.sv
// Remote serial transmitter driving the receive line
`default_nettype none
module usf_far_end #(
  parameter int BITC = 16
) (
  input wire logic pclk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // One frame, LSB first; optional one-clock glitch inside the start bit
  task automatic send(input logic [8:0] d, input logic nine, input logic glitch);
    int i;
    int k;
    logic b;
    for (i = 0; i < (nine ? 11 : 10); i++) begin
      b = (i == 0) ? 1'b0 : (i > (nine ? 9 : 8)) ? 1'b1 : d[i - 1];
      for (k = 0; k < BITC; k++) begin
        @(posedge pclk);
        line <= (glitch && i == 0 && k == 7) ? 1'b1 : b;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb/usf_top_tb_top.sv
// Self-checking bench for the serial status block
`include "usf_map.vh"
`default_nettype none
module usf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = 16;
  localparam logic [7:0] ST = `USF_OFS_STATUS;
  localparam logic [7:0] DT = `USF_OFS_DATA;
  localparam logic [7:0] CT = `USF_OFS_CTRL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdv;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic rxd_line;
  wire logic txd_line;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  usf_top u_usf_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_line), .txd_pin(txd_line));
  usf_far_end u_usf_far_end (.pclk(pclk), .line(rxd_line));
  // ====
  // Helpers
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, e & m, rdv & m);
  endtask
  task automatic clr;
    repeat (12 * BITC) @(posedge pclk);
    apb(1'b0, ST, 32'h0);
    apb(1'b0, DT, 32'h0);
  endtask
  // ====
  // Scenarios
  task automatic t_reset;
    rdm(ST, 32'hffffffff, 32'hc0, "status");
    rdm(CT, 32'hff, {24'h0, `USF_CTRL_RST}, "ctrl");
    rdm(`USF_OFS_BAUD, 32'hffff, {16'h0, `USF_BAUD_RST}, "baud");
    rdm(8'h10, 32'hffffffff, 32'h0, "unmapped");
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, ST, 32'h3c);
    rdm(ST, 32'hffffffff, 32'hc0, "status ro");
    apb(1'b1, `USF_OFS_BAUD, 32'h0);
  endtask
  task automatic t_rx_idle;
    u_usf_far_end.send(9'h0a5, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    rdm(ST, 32'hff, 32'he0, "status full");
    rdm(DT, 32'h1ff, 32'h0a5, "rx data");
    rdm(ST, 32'hff, 32'hc0, "full cleared");
    repeat (12 * BITC) @(posedge pclk);
    rdm(ST, 32'hff, 32'hd0, "idle set");
    apb(1'b0, DT, 32'h0);
    rdm(ST, 32'hff, 32'hc0, "idle cleared");
    repeat (24 * BITC) @(posedge pclk);
    rdm(ST, 32'hff, 32'hc0, "idle rearm");
  endtask
  task automatic idle_case(input logic [7:0] ctl, input logic [8:0] d, input int w,
    input logic e);
    clr();
    apb(1'b1, CT, {24'h0, ctl});
    u_usf_far_end.send(d, ctl[`USF_CT_LONG], 1'b0);
    repeat (w) @(posedge pclk);
    rdm(ST, 32'h10, {27'h0, e, 4'h0}, "idle timing");
  endtask
  task automatic t_overrun;
    apb(1'b1, CT, 32'h0);
    clr();
    u_usf_far_end.send(9'h011, 1'b0, 1'b0);
    u_usf_far_end.send(9'h022, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    rdm(ST, 32'hff, 32'he8, "overrun");
    rdm(DT, 32'h1ff, 32'h011, "kept char");
    rdm(ST, 32'hff, 32'hc0, "overrun cleared");
  endtask
  task automatic t_noise;
    u_usf_far_end.send(9'h05a, 1'b0, 1'b1);
    repeat (4) @(posedge pclk);
    rdm(ST, 32'hff, 32'he4, "noise");
    rdm(DT, 32'h1ff, 32'h05a, "noisy char");
    rdm(ST, 32'hff, 32'hc0, "noise cleared");
  endtask
  task automatic t_tx;
    rdm(ST, 32'h40, 32'h40, "done idle");
    apb(1'b1, CT, 32'h2);
    rdm(ST, 32'h40, 32'h0, "done preamble");
    repeat (12 * BITC) @(posedge pclk);
    rdm(ST, 32'h40, 32'h40, "done after preamble");
    apb(1'b1, DT, 32'h55);
    rdm(ST, 32'h40, 32'h0, "done data");
    repeat (24 * BITC) @(posedge pclk);
    rdm(ST, 32'h40, 32'h40, "done after data");
    apb(1'b1, CT, 32'h3);
    rdm(ST, 32'h40, 32'h0, "done break");
    repeat (4 * BITC) @(posedge pclk);
    check("break line", 32'h0, {31'h0, txd_line});
    apb(1'b1, CT, 32'h2);
    repeat (36 * BITC) @(posedge pclk);
    rdm(ST, 32'h40, 32'h40, "done after break");
  endtask
  // ====
  // Main sequence and timeout
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_rx_idle();
    idle_case(8'h00, 9'h0ff, 5 * BITC, 1'b1);
    idle_case(8'h10, 9'h0ff, 5 * BITC, 1'b0);
    idle_case(8'h10, 9'h0ff, 10 * BITC + 10, 1'b1);
    idle_case(8'h10, 9'h0ff, 9 * BITC + 6, 1'b1);
    idle_case(8'h18, 9'h1ff, 9 * BITC + 6, 1'b0);
    idle_case(8'h18, 9'h1ff, 10 * BITC + 10, 1'b1);
    t_overrun();
    t_noise();
    t_tx();
    report_and_stop();
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
